/* src/sfrp_read_path.v */
/*
  Read path of a serial flash: opcode and address capture, dummy phase,
  single and dual output, with a two-entry prefetch buffer in front of
  the shifter.
  Assumes cs_n, sck and si come from an outside host and are sampled
  by clk_in; the byte store answers fetch requests on the fetch port.
*/
`timescale 1ns/10ps
`include "sfrp_map.vh"

// Overview of operation
// R1: Opcodes 03h and 0Bh both start a single-line array read.
// R2: Host shifts the 8-bit opcode in on the input line, MSB first.
// R3: Host then shifts a 24-bit start address in, bit 23 first; the status read 65h takes only an 8-bit pointer instead.
// R4: Every read except the plain single read 03h has a dummy byte before data.
// R5: Single reads shift each byte out MSB first, as long as clocked.
// R6: An internal read address counter advances once per byte.
// R7: Chip select high aborts the read and floats the output line.
// R8: After the last array byte, reading continues at zero without delay.
// R9: Dual read: opcode, address on input line, then one dummy byte.
// R10: Dual read turns the input line into an output for data.
// R11: Dual read: four clocks per byte, high bit on output line first.
// R12: Chip select high in dual read floats both lines at once.
// R13: Status read from pointer 01h streams all five registers in order.
// R14: Parameter table read streams successive locations from the address.
// R15: Inputs sampled on rising serial clock, outputs changed on falling.
module sfrp_read_path (
  // System
  input  wire        clk_in,
  input  wire        nrst_in,
  // Serial link pins
  input  wire        cs_n_in,
  input  wire        sck_in,
  input  wire        si_in,
  output wire        si_out,
  output wire        si_oe_out,
  output wire        so_out,
  output wire        so_oe_out,
  // Fetch request
  output wire        rd_req_out,
  input  wire        rd_gnt_in,
  output wire [23:0] rd_addr_out,
  output wire [1:0]  rd_space_out,
  // Fetch answer
  input  wire        rd_valid_in,
  input  wire [7:0]  rd_data_in,
  output wire        rd_ready_out
);

  localparam ST_CMD    = 3'h0;
  localparam ST_ADDR   = 3'h1;
  localparam ST_DUMMY  = 3'h2;
  localparam ST_DATA   = 3'h3;
  localparam ST_IGNORE = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // Next fetch address, wrapping per space
  function [23:0] sfrp_next_addr;
    input [1:0]  space;
    input [23:0] addr;
    begin
      case (space)
        `SFRP_SPACE_ARRAY:
          sfrp_next_addr = (addr >= `SFRP_ARRAY_LAST) ? `SFRP_ARRAY_FIRST
                                                     : addr + 24'h000001;
        `SFRP_SPACE_STAT:
          sfrp_next_addr = (addr >= `SFRP_STAT_LAST) ? `SFRP_STAT_FIRST
                                                    : addr + 24'h000001;
        default:
          sfrp_next_addr = addr + 24'h000001;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg  [1:0]  cs_sync_reg;
  reg  [2:0]  sck_sync_reg;
  reg  [1:0]  si_sync_reg;

  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cs_sync_reg  <= 2'h3;
      sck_sync_reg <= 3'h0;
      si_sync_reg  <= 2'h0;
    end
    else
    begin
      cs_sync_reg  <= {cs_sync_reg[0], cs_n_in};
      sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
      si_sync_reg  <= {si_sync_reg[0], si_in};
    end
  end

  wire        cs_act   = ~cs_sync_reg[1];
  wire        si_s     = si_sync_reg[1];
  wire        sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];  // see R15
  wire        sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];  // see R15

  ////////////////////////////////////////////////////////////////////////
  // Protocol state
  reg  [2:0]  state_reg;
  reg  [4:0]  bit_cnt_reg;
  reg  [23:0] in_sh_reg;
  reg         dual_reg;
  reg         dummy_reg;
  reg         addr1_reg;
  reg  [1:0]  space_reg;
  reg         fetch_en_reg;
  reg  [23:0] fetch_addr_reg;
  reg  [2:0]  out_cnt_reg;
  reg  [7:0]  out_sh_reg;
  reg         so_reg;
  reg         si_o_reg;
  reg         so_oe_reg;
  reg         si_oe_reg;

  // Buffer state
  reg  [7:0]  buf_mem [0:1];
  reg         wr_ptr_reg;
  reg         rd_ptr_reg;
  reg  [1:0]  occ_reg;
  reg  [1:0]  pend_reg;

  wire [23:0] next_sh  = {in_sh_reg[22:0], si_s};
  wire [4:0]  addr_last = addr1_reg ? `SFRP_ADDR1_LAST : `SFRP_ADDR3_LAST;
  wire [2:0]  out_last  = dual_reg ? `SFRP_DUAL_LAST : `SFRP_SINGLE_LAST;

  // Credits cover words held plus words still in flight
  wire [2:0]  used      = {1'b0, occ_reg} + {1'b0, pend_reg};
  wire        buf_full  = ({1'b0, occ_reg} == `SFRP_BUF_DEPTH);
  wire        req       = fetch_en_reg & (used < `SFRP_BUF_DEPTH);
  wire        fire      = req & rd_gnt_in;
  wire        ack       = rd_valid_in & ~buf_full;
  wire        push      = ack & fetch_en_reg & cs_act;
  wire        pop       = cs_act & sck_fall & (state_reg == ST_DATA) &
                          (out_cnt_reg == 3'h0) & (occ_reg != 2'h0);
  wire [7:0]  head      = (occ_reg != 2'h0) ? buf_mem[rd_ptr_reg] : 8'h00;
  wire [7:0]  cur_byte  = (out_cnt_reg == 3'h0) ? head : out_sh_reg;

  assign rd_req_out   = req;
  assign rd_ready_out = ~buf_full;
  assign rd_addr_out  = fetch_addr_reg;
  assign rd_space_out = space_reg;
  assign so_out       = so_reg;
  assign si_out       = si_o_reg;
  assign so_oe_out    = so_oe_reg;
  assign si_oe_out    = si_oe_reg;

  ////////////////////////////////////////////////////////////////////////
  // Command, address and dummy capture
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_reg      <= ST_CMD;
      bit_cnt_reg    <= 5'h00;
      in_sh_reg      <= 24'h000000;
      dual_reg       <= 1'b0;
      dummy_reg      <= 1'b0;
      addr1_reg      <= 1'b0;
      space_reg      <= `SFRP_SPACE_ARRAY;
      fetch_en_reg   <= 1'b0;
      fetch_addr_reg <= 24'h000000;
    end
    else if (!cs_act)
    begin
      state_reg    <= ST_CMD;       // see R7
      bit_cnt_reg  <= 5'h00;
      fetch_en_reg <= 1'b0;         // see R12
    end
    else
    begin
      if (fire)
        fetch_addr_reg <= sfrp_next_addr(space_reg, fetch_addr_reg);  // see R6, R8
      if (sck_rise)
      begin
        in_sh_reg <= next_sh;
        case (state_reg)
          ST_CMD:
          begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == `SFRP_CMD_LAST)          // see R2
            begin
              bit_cnt_reg <= 5'h00;
              state_reg   <= ST_ADDR;
              dual_reg    <= (next_sh[7:0] == `SFRP_OP_DUAL);
              addr1_reg   <= (next_sh[7:0] == `SFRP_OP_STAT);
              dummy_reg   <= (next_sh[7:0] != `SFRP_OP_READ);  // see R4, R9
              case (next_sh[7:0])
                `SFRP_OP_READ,
                `SFRP_OP_FAST,
                `SFRP_OP_DUAL: space_reg <= `SFRP_SPACE_ARRAY;  // see R1
                `SFRP_OP_STAT: space_reg <= `SFRP_SPACE_STAT;
                `SFRP_OP_DISCOVERABLE_PARAMETER_TABLE: space_reg <= `SFRP_SPACE_DISCOVERABLE_PARAMETER_TABLE;
                default:       state_reg <= ST_IGNORE;
              endcase
            end
          end
          ST_ADDR:
          begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == addr_last)                // see R3
            begin
              bit_cnt_reg    <= 5'h00;
              fetch_en_reg   <= 1'b1;
              fetch_addr_reg <= addr1_reg ? {16'h0000, next_sh[7:0]} : next_sh;  // see R13, R14
              state_reg      <= dummy_reg ? ST_DUMMY : ST_DATA;
            end
          end
          ST_DUMMY:
          begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == `SFRP_DUMMY_LAST)         // see R4, R9
            begin
              bit_cnt_reg <= 5'h00;
              state_reg   <= ST_DATA;
            end
          end
          ST_DATA,
          ST_IGNORE:
            state_reg <= state_reg;
          default:
            state_reg <= ST_IGNORE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output shifter, driven on falling serial clock
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      out_cnt_reg <= 3'h0;
      out_sh_reg  <= 8'h00;
      so_reg      <= 1'b0;
      si_o_reg    <= 1'b0;
      so_oe_reg   <= 1'b0;
      si_oe_reg   <= 1'b0;
    end
    else if (!cs_act)
    begin
      out_cnt_reg <= 3'h0;
      so_oe_reg   <= 1'b0;          // see R7, R12
      si_oe_reg   <= 1'b0;          // see R12
    end
    else if (sck_fall && state_reg == ST_DATA)
    begin
      so_oe_reg <= 1'b1;
      si_oe_reg <= dual_reg;        // see R10
      so_reg    <= cur_byte[7];     // see R5, R11
      si_o_reg  <= cur_byte[6];     // see R11
      if (dual_reg)
        out_sh_reg <= {cur_byte[5:0], 2'h0};
      else
        out_sh_reg <= {cur_byte[6:0], 1'b0};
      out_cnt_reg <= (out_cnt_reg == out_last) ? 3'h0 : out_cnt_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-entry buffer; stale answers after an abort are drained, not kept
  always @(posedge clk_in)
  begin
    if (push)
      buf_mem[wr_ptr_reg] <= rd_data_in;
  end

  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      occ_reg    <= 2'h0;
      pend_reg   <= 2'h0;
    end
    else
    begin
      case ({fire, ack & (pend_reg != 2'h0)})
        2'b10:   pend_reg <= pend_reg + 2'h1;
        2'b01:   pend_reg <= pend_reg - 2'h1;
        default: pend_reg <= pend_reg;
      endcase
      if (!cs_act)
      begin
        wr_ptr_reg <= 1'b0;
        rd_ptr_reg <= 1'b0;
        occ_reg    <= 2'h0;
      end
      else
      begin
        if (push)
          wr_ptr_reg <= ~wr_ptr_reg;
        if (pop)
          rd_ptr_reg <= ~rd_ptr_reg;
        case ({push, pop})
          2'b10:   occ_reg <= occ_reg + 2'h1;
          2'b01:   occ_reg <= occ_reg - 2'h1;
          default: occ_reg <= occ_reg;
        endcase
      end
    end
  end

endmodule

/* src/sfrp_map.vh */
/*
  Constants of the serial flash read path: opcodes, phase lengths,
  address spaces and wrap points.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SFRP_MAP_VH
`define SFRP_MAP_VH

// Opcodes
`define SFRP_OP_READ      8'h03
`define SFRP_OP_FAST      8'h0B
`define SFRP_OP_DUAL      8'h3B
`define SFRP_OP_STAT      8'h65
`define SFRP_OP_DISCOVERABLE_PARAMETER_TABLE      8'h5A

// Phase lengths in serial clocks, as last bit index
`define SFRP_CMD_LAST     5'h07
`define SFRP_ADDR3_LAST   5'h17
`define SFRP_ADDR1_LAST   5'h07
`define SFRP_DUMMY_LAST   5'h07

// Output clocks per byte, as last index
`define SFRP_SINGLE_LAST  3'h7
`define SFRP_DUAL_LAST    3'h3

// Address spaces on the fetch port
`define SFRP_SPACE_ARRAY  2'h0
`define SFRP_SPACE_STAT   2'h1
`define SFRP_SPACE_DISCOVERABLE_PARAMETER_TABLE   2'h2

// Wrap points
`define SFRP_ARRAY_LAST   24'h07FFFF
`define SFRP_ARRAY_FIRST  24'h000000
`define SFRP_STAT_FIRST   24'h000001
`define SFRP_STAT_LAST    24'h000005

// Buffer
`define SFRP_BUF_DEPTH    3'h2

// Timing
`define SFRP_CLK_NS       50

`endif

/* testbench/sfrp_checker.sv */
/* Port assertions for the flash read path.
   Bound to sfrp_read_path; one clock domain. */
`timescale 1ns/10ps
module sfrp_checker (
  // System
  input wire logic        clk_in,
  input wire logic        nrst_in,
  // Link
  input wire logic        cs_n_in,
  input wire logic        sck_in,
  input wire logic        si_out,
  input wire logic        si_oe_out,
  input wire logic        so_out,
  input wire logic        so_oe_out,
  // Fetch
  input wire logic        rd_req_out,
  input wire logic        rd_gnt_in,
  input wire logic [23:0] rd_addr_out,
  input wire logic [1:0]  rd_space_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////
  sequence take_arr;
    rd_req_out && rd_gnt_in && rd_space_out == 2'h0;
  endsequence
  sequence take_stat;
    rd_req_out && rd_gnt_in && rd_space_out == 2'h1;
  endsequence
  ////////////////////////////////////////////////////////////////
  // Four clocks covers the pin synchroniser delay
  a_idle_quiet: assert property (cs_n_in [*4] |-> !so_oe_out && !si_oe_out)
    else $error("data lines driven while deselected");
  a_dual_both: assert property (si_oe_out |-> so_oe_out)
    else $error("input line driven alone");
  a_dual_start: assert property ($rose(si_oe_out) |-> $rose(so_oe_out))
    else $error("dual lines not turned together");
  a_oe_framed: assert property ($rose(so_oe_out) |-> !cs_n_in)
    else $error("output enabled outside a frame");
  a_addr_inc: assert property (take_arr ##1 rd_req_out && $past(rd_addr_out) != 24'h07FFFF
    |-> rd_addr_out == $past(rd_addr_out) + 24'h000001)
    else $error("address did not step by one");
  a_addr_wrap: assert property (take_arr ##1 rd_req_out && $past(rd_addr_out) == 24'h07FFFF
    |-> rd_addr_out == 24'h000000)
    else $error("address did not wrap to zero");
  a_stat_wrap: assert property (take_stat ##1 rd_req_out && $past(rd_addr_out) == 24'h000005
    |-> rd_addr_out == 24'h000001)
    else $error("status pointer did not wrap");
  a_addr_hold: assert property (rd_req_out && !rd_gnt_in ##1 rd_req_out |-> $stable(rd_addr_out))
    else $error("address moved without a take");
  a_out_on_fall: assert property (so_oe_out && $past(so_oe_out) && $changed(so_out)
    |-> !$past(sck_in))
    else $error("output changed while serial clock high");
endmodule
bind sfrp_read_path sfrp_checker u_chk (.clk_in, .nrst_in, .cs_n_in, .sck_in, .si_out,
  .si_oe_out, .so_out, .so_oe_out, .rd_req_out, .rd_gnt_in, .rd_addr_out, .rd_space_out);

/* testbench/sfrp_host.sv */
/* Host model of the serial link: select, clock, command bits.
   Assumes a 400 ns serial clock, off the system clock grid. */
`timescale 1ns/10ps
module sfrp_host (
  // Device side
  input  wire logic so_in,
  input  wire logic so_oe_in,
  input  wire logic si_drv_in,
  input  wire logic si_oe_in,
  // Link
  output logic      cs_n_out,
  output logic      sck_out,
  output wire logic si_out
);
  logic       si_h;
  logic       h_oe;
  logic [7:0] rxb [0:7];
  // Released line shows the inverse, no pull on it
  assign si_out = si_oe_in ? si_drv_in : (h_oe ? si_h : ~si_h);
  initial
  begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_h = 1'b0;
    h_oe = 1'b1;
  end
  task automatic shift_in(input logic b);
    si_h = b;
    #200 sck_out = 1'b1;
    #200 sck_out = 1'b0;
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na, nd,
                       input bit dual, input int nclk);
    int i;
    logic [7:0] sh;
    h_oe = 1'b1;
    cs_n_out = 1'b0;
    #207;
    for (i = 7; i >= 0; i--) shift_in(op[i]);
    for (i = na - 1; i >= 0; i--) shift_in(a[i]);
    repeat (nd) shift_in(1'b0);
    h_oe = 1'b0;
    sh = 8'h00;
    for (i = 0; i < nclk; i++)
    begin
      #200 sck_out = 1'b1;
      if (dual)
        sh = {sh[5:0], so_oe_in ? so_in : 1'bx, si_oe_in ? si_drv_in : 1'bx};
      else
        sh = {sh[6:0], so_oe_in ? so_in : 1'bx};
      if ((i + 1) % (dual ? 4 : 8) == 0)
        rxb[(i + 1) / (dual ? 4 : 8) - 1] = sh;
      #200 sck_out = 1'b0;
    end
    #7 cs_n_out = 1'b1;
    h_oe = 1'b1;
  endtask
endmodule

/* testbench/sfrp_read_path_bench.sv */
/* Bench for the flash read path.
   Host model drives the link; a queue answers fetches. */
`timescale 1ns/10ps
`include "sfrp_map.vh"
module sfrp_read_path_bench;
  logic        clk_in, nrst_in;
  logic        rd_gnt_in = 1'b0, rd_valid_in = 1'b0, tk_reg = 1'b0, ak_reg = 1'b0;
  logic [7:0]  rd_data_in = 8'h00, tk_val = 8'h00;
  wire         cs_n_in, sck_in, si_in, si_out, si_oe_out, so_out, so_oe_out;
  wire         rd_req_out, rd_ready_out;
  wire  [23:0] rd_addr_out;
  wire  [1:0]  rd_space_out;
  logic [7:0]  q [$];
  int          n_errors = 0, comparisons = 0, cyc = 0, takes = 0, k;
  sfrp_read_path dut (.clk_in, .nrst_in, .cs_n_in, .sck_in, .si_in, .si_out, .si_oe_out,
    .so_out, .so_oe_out, .rd_req_out, .rd_gnt_in, .rd_addr_out, .rd_space_out,
    .rd_valid_in, .rd_data_in, .rd_ready_out);
  sfrp_host u_host (.so_in(so_out), .so_oe_in(so_oe_out), .si_drv_in(si_out),
    .si_oe_in(si_oe_out), .cs_n_out(cs_n_in), .sck_out(sck_in), .si_out(si_in));
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] mem(input logic [1:0] s, input logic [23:0] a);
    mem = a[7:0] + {a[19:16], 2'h0, s};
  endfunction
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Grant every other cycle, so requests also wait
  always @(negedge clk_in) rd_gnt_in <= !rd_gnt_in;
  // Takes and answer handshakes are seen at the rising edge
  always @(posedge clk_in)
  begin
    tk_reg <= nrst_in && rd_req_out && rd_gnt_in;
    tk_val <= mem(rd_space_out, rd_addr_out);
    ak_reg <= rd_valid_in && rd_ready_out;
    if (nrst_in && rd_req_out && rd_gnt_in)
      takes++;
  end
  // Answers change only at the falling edge, in request order
  always @(negedge clk_in)
    if (!nrst_in)
    begin
      q.delete();
      rd_valid_in = 1'b0;
    end
    else
    begin
      if (tk_reg)
        q.push_back(tk_val);
      if (!rd_valid_in || ak_reg)
      begin
        rd_valid_in = q.size() != 0;
        if (q.size() != 0)
          rd_data_in = q.pop_front();
      end
    end
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic run(input logic [7:0] op, input logic [23:0] a, input int na, nd,
                     input bit dual, input int nclk);
    u_host.frame(op, a, na, nd, dual, nclk);
    repeat (4) @(negedge clk_in);
  endtask
  task automatic t_plain_wrap;
    run(`SFRP_OP_READ, 24'h07FFFE, 24, 0, 1'b0, 24);
    chk("plain0", mem(2'h0, 24'h07FFFE), u_host.rxb[0]);
    chk("plain1", mem(2'h0, 24'h07FFFF), u_host.rxb[1]);
    chk("plain2", mem(2'h0, 24'h000000), u_host.rxb[2]);
  endtask
  task automatic t_fast;
    run(`SFRP_OP_FAST, 24'h031234, 24, 8, 1'b0, 16);
    chk("fast0", mem(2'h0, 24'h031234), u_host.rxb[0]);
    chk("fast1", mem(2'h0, 24'h031235), u_host.rxb[1]);
  endtask
  task automatic t_dual;
    run(`SFRP_OP_DUAL, 24'h07FFFF, 24, 8, 1'b1, 8);
    chk("dual0", mem(2'h0, 24'h07FFFF), u_host.rxb[0]);
    chk("dual1", mem(2'h0, 24'h000000), u_host.rxb[1]);
  endtask
  task automatic t_stat;
    run(`SFRP_OP_STAT, 24'h000001, 8, 8, 1'b0, 48);
    for (k = 0; k < 6; k++) chk("stat", mem(2'h1, k % 5 + 1), u_host.rxb[k]);
  endtask
  task automatic t_table;
    run(`SFRP_OP_DISCOVERABLE_PARAMETER_TABLE, 24'h000000, 24, 8, 1'b0, 16);
    chk("table0", mem(2'h2, 24'h000000), u_host.rxb[0]);
    chk("table1", mem(2'h2, 24'h000001), u_host.rxb[1]);
  endtask
  task automatic t_abort;
    run(`SFRP_OP_DUAL, 24'h000040, 24, 8, 1'b1, 2);
    chk("dual abort oe", 8'h00, {6'h00, so_oe_out, si_oe_out});
    run(`SFRP_OP_READ, 24'h000040, 24, 0, 1'b0, 5);
    chk("single abort oe", 8'h00, {7'h00, so_oe_out});
  endtask
  task automatic t_refused;
    k = takes;
    run(8'h9F, 24'h000000, 24, 0, 1'b0, 8);
    chk("refused takes", 8'(k), 8'(takes));
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    nrst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    t_plain_wrap();
    t_fast();
    t_dual();
    t_stat();
    t_table();
    t_abort();
    t_refused();
    tally_and_finish();
  end
endmodule
